// file: rtl/ppm_map.svh
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH
// pin counts: port 0 is indices 0..31, port 1 pin n is index 32+n
`define PPM_NUM_P0 32
`define PPM_NUM_P1 16
`define PPM_NUM_PINS 48
`define PPM_SIG_IDX_W 6
// fixed pins of the dedicated functions, as pin indices
`define PPM_PIN_XTAL_IN 6'h00
`define PPM_PIN_XTAL_OUT 6'h01
`define PPM_PIN_NFC_A 6'h09
`define PPM_PIN_NFC_B 6'h0A
`define PPM_PIN_RESET 6'h12
`define PPM_PIN_TRACE_CLK 6'h07
`define PPM_PIN_TRACE_D0 6'h20
`define PPM_PIN_TRACE_D1 6'h0C
`define PPM_PIN_TRACE_D2 6'h0B
`define PPM_PIN_TRACE_D3 6'h29
// analog channels 0..3 start at P0.02, channels 4..7 at P0.28
`define PPM_PIN_ANA_LO 6'h02
`define PPM_PIN_ANA_HI 6'h18
`define PPM_NUM_ANA 8
// shared register slots
`define PPM_SLOT_BASE_0 32'h40003000
`define PPM_SLOT_BASE_1 32'h40004000
`define PPM_NUM_SLOTS 2
`endif

// file: rtl/ppm_pkg.sv
package ppm_pkg;
`include "ppm_map.svh"

  // per-pin routing choice from the configuration logic
  typedef struct packed {
    logic route_en;                          // pin carries a peripheral signal
    logic [`PPM_SIG_IDX_W-1:0] sig_idx;      // which peripheral signal
  } ppm_pin_cfg_type;

  // enables of the pin-bound functions
  typedef struct packed {
    logic [`PPM_NUM_ANA-1:0] analog_input_channels;
    logic reset_pin;
    logic trace;
    logic slow_crystal;
    logic nearfield_antenna;
  } ppm_dedicated_en_type;

  // ownership of one shared register slot
  typedef enum logic [2:0] {
    SLOT_FREE = 3'b001,
    SLOT_SPI = 3'b010,
    SLOT_I2C = 3'b100
  } ppm_slot_state_type;
endpackage : ppm_pkg

// file: rtl/ppm_pin_mux.sv
// Behaviour
// [RQ1] any general peripheral signal on any pin
// [RQ2] each pin carries at most one signal
// [RQ3] analog on fixed pins; reset on P0.18
// [RQ4] trace clock and data on fixed pins
// [RQ5] crystal, antenna fixed; debug, USB off-port
// [RQ6] shared slot: SPI or I2C, never both
// [RQ7] software clears old config before switching
// [RQ8] unrouted pins stay plain general-purpose I/O
`timescale 1ns/1ps
`include "ppm_map.svh"
module ppm_pin_mux
  import ppm_pkg::*;
#(
  parameter int NUM_SIG = 40
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire ppm_pin_cfg_type [`PPM_NUM_PINS-1:0] PIN_CFG_I,
  input wire logic [NUM_SIG-1:0] PERIPH_OUT_I,
  input wire logic [NUM_SIG-1:0] PERIPH_OE_I,
  output logic [NUM_SIG-1:0] PERIPH_IN_O,
  input wire logic [`PPM_NUM_PINS-1:0] GPIO_OUT_I,
  input wire logic [`PPM_NUM_PINS-1:0] GPIO_OE_I,
  output logic [`PPM_NUM_PINS-1:0] GPIO_IN_O,
  input wire logic [`PPM_NUM_PINS-1:0] PAD_IN_I,
  output logic [`PPM_NUM_PINS-1:0] PAD_OUT_O,
  output logic [`PPM_NUM_PINS-1:0] PAD_OE_O,
  input wire ppm_dedicated_en_type DEDICATED_EN_I,
  input wire logic TRACE_CLOCK_OUT_I,
  input wire logic [3:0] TRACE_DATA_BUS_I,
  output logic RESET_PIN_N_O,
  output logic [`PPM_NUM_PINS-1:0] ROUTE_CLASH_O,
  input wire logic [`PPM_NUM_SLOTS-1:0] SLOT_SPI_REQ_I,
  input wire logic [`PPM_NUM_SLOTS-1:0] SLOT_I2C_REQ_I,
  output logic [`PPM_NUM_SLOTS-1:0] SLOT_SPI_ACT_O,
  output logic [`PPM_NUM_SLOTS-1:0] SLOT_I2C_ACT_O
);
  localparam int NP = `PPM_NUM_PINS;

  // pin index of an analog channel
  function automatic logic [5:0] ana_pin(input int unsigned ch);
    ana_pin = (ch < 4) ? (`PPM_PIN_ANA_LO + 6'(ch)) : (`PPM_PIN_ANA_HI + 6'(ch));
  endfunction : ana_pin

  // pin index of a trace data bit
  function automatic logic [5:0] trace_pin(input int unsigned b);
    case (b)
      0: trace_pin = `PPM_PIN_TRACE_D0;
      1: trace_pin = `PPM_PIN_TRACE_D1;
      2: trace_pin = `PPM_PIN_TRACE_D2;
      default: trace_pin = `PPM_PIN_TRACE_D3;
    endcase
  endfunction : trace_pin

  logic [NP-1:0] pad_meta_q;       // first synchroniser stage, read by pad_sync_q only
  logic [NP-1:0] pad_sync_q;       // pad levels in the clock domain
  logic [NP-1:0] claim_w;          // pin held by a dedicated function
  logic [NP-1:0] ded_out_w;        // dedicated output level
  logic [NP-1:0] ded_oe_w;         // dedicated output enable
  logic [NP-1:0] route_ok_w;       // pin asks for a valid peripheral signal
  logic [NP-1:0] pad_out_d, pad_out_q;
  logic [NP-1:0] pad_oe_d, pad_oe_q;
  logic [NP-1:0] clash_d, clash_q;
  logic [NP-1:0] gpio_in_q;        // pad level shown to the general-purpose block
  logic [NUM_SIG-1:0] periph_in_d, periph_in_q;
  logic reset_n_d, reset_n_q;

  // pad synchroniser: pads are asynchronous to the clock
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pad_meta_q <= '0;
      pad_sync_q <= '0;
    end else begin
      pad_meta_q <= PAD_IN_I;
      pad_sync_q <= pad_meta_q;
    end
  end

  // which pins the enabled dedicated functions take over
  always_comb begin
    claim_w = '0;
    ded_out_w = '0;
    ded_oe_w = '0;
    // crystal and antenna pads are analog: output released
    if (DEDICATED_EN_I.slow_crystal) begin
      claim_w[`PPM_PIN_XTAL_IN] = 1'b1; // [RQ5]
      claim_w[`PPM_PIN_XTAL_OUT] = 1'b1; // [RQ5]
    end
    if (DEDICATED_EN_I.nearfield_antenna) begin
      claim_w[`PPM_PIN_NFC_A] = 1'b1; // [RQ5]
      claim_w[`PPM_PIN_NFC_B] = 1'b1; // [RQ5]
    end
    // reset pin is input only
    if (DEDICATED_EN_I.reset_pin) begin
      claim_w[`PPM_PIN_RESET] = 1'b1; // [RQ3]
    end
    // trace port drives its fixed pins
    if (DEDICATED_EN_I.trace) begin
      claim_w[`PPM_PIN_TRACE_CLK] = 1'b1; // [RQ4]
      ded_out_w[`PPM_PIN_TRACE_CLK] = TRACE_CLOCK_OUT_I; // [RQ4]
      ded_oe_w[`PPM_PIN_TRACE_CLK] = 1'b1;
      for (int b = 0; b < 4; b++) begin
        claim_w[trace_pin(b)] = 1'b1; // [RQ4]
        ded_out_w[trace_pin(b)] = TRACE_DATA_BUS_I[b]; // [RQ4]
        ded_oe_w[trace_pin(b)] = 1'b1;
      end
    end
    // analog channels release their pad to the converter
    for (int ch = 0; ch < `PPM_NUM_ANA; ch++) begin
      if (DEDICATED_EN_I.analog_input_channels[ch]) begin
        claim_w[ana_pin(ch)] = 1'b1; // [RQ3]
      end
    end
  end

  // per pin: one source only, dedicated over peripheral over gpio
  always_comb begin
    pad_out_d = '0;
    pad_oe_d = '0;
    clash_d = '0;
    route_ok_w = '0;
    for (int p = 0; p < NP; p++) begin
      // an index past the last signal is treated as no route
      route_ok_w[p] = PIN_CFG_I[p].route_en && (int'(PIN_CFG_I[p].sig_idx) < NUM_SIG);
      if (claim_w[p]) begin
        // dedicated circuitry wins; a peripheral asking too is flagged
        pad_out_d[p] = ded_out_w[p]; // [RQ2]
        pad_oe_d[p] = ded_oe_w[p];
        clash_d[p] = route_ok_w[p]; // [RQ2]
      end else if (route_ok_w[p]) begin
        pad_out_d[p] = PERIPH_OUT_I[PIN_CFG_I[p].sig_idx]; // [RQ1]
        pad_oe_d[p] = PERIPH_OE_I[PIN_CFG_I[p].sig_idx]; // [RQ1]
      end else begin
        pad_out_d[p] = GPIO_OUT_I[p]; // [RQ8]
        pad_oe_d[p] = GPIO_OE_I[p]; // [RQ8]
      end
    end
  end

  // peripheral inputs; several pins on one signal are ORed, a user fault
  always_comb begin
    periph_in_d = '0;
    for (int s = 0; s < NUM_SIG; s++) begin
      for (int p = 0; p < NP; p++) begin
        if (route_ok_w[p] && !claim_w[p] && (int'(PIN_CFG_I[p].sig_idx) == s)) begin
          periph_in_d[s] = periph_in_d[s] | pad_sync_q[p]; // [RQ1]
        end
      end
    end
    // reset pin idles high when not in use
    reset_n_d = DEDICATED_EN_I.reset_pin ? pad_sync_q[`PPM_PIN_RESET] : 1'b1; // [RQ3]
  end

  // pin state registers; pads stay released during reset
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
      clash_q <= '0;
      gpio_in_q <= '0;
      periph_in_q <= '0;
      reset_n_q <= 1'b1;
    end else begin
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
      clash_q <= clash_d;
      gpio_in_q <= pad_sync_q;
      periph_in_q <= periph_in_d;
      reset_n_q <= reset_n_d;
    end
  end

  // shared slot ownership: one state machine per slot
  ppm_slot_state_type slot_d [`PPM_NUM_SLOTS];
  ppm_slot_state_type slot_q [`PPM_NUM_SLOTS];
  logic [`PPM_NUM_SLOTS-1:0] spi_act_q, i2c_act_q;

  // owner is held until its own configuration is cleared by software,
  // so a request of the partner meanwhile is simply not granted
  always_comb begin
    for (int k = 0; k < `PPM_NUM_SLOTS; k++) begin
      slot_d[k] = slot_q[k];
      case (slot_q[k])
        SLOT_FREE: begin
          if (SLOT_SPI_REQ_I[k]) begin
            slot_d[k] = SLOT_SPI; // [RQ6]
          end else if (SLOT_I2C_REQ_I[k]) begin
            slot_d[k] = SLOT_I2C; // [RQ6]
          end
        end
        SLOT_SPI: begin
          if (!SLOT_SPI_REQ_I[k]) begin
            slot_d[k] = SLOT_FREE; // [RQ7]
          end
        end
        SLOT_I2C: begin
          if (!SLOT_I2C_REQ_I[k]) begin
            slot_d[k] = SLOT_FREE; // [RQ7]
          end
        end
        default: slot_d[k] = SLOT_FREE;
      endcase
    end
  end

  // slot registers; active flags registered from the next state
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int k = 0; k < `PPM_NUM_SLOTS; k++) begin
        slot_q[k] <= SLOT_FREE;
      end
      spi_act_q <= '0;
      i2c_act_q <= '0;
    end else begin
      for (int k = 0; k < `PPM_NUM_SLOTS; k++) begin
        slot_q[k] <= slot_d[k];
        spi_act_q[k] <= (slot_d[k] == SLOT_SPI); // [RQ6]
        i2c_act_q[k] <= (slot_d[k] == SLOT_I2C); // [RQ6]
      end
    end
  end

  assign PAD_OUT_O = pad_out_q;
  assign PAD_OE_O = pad_oe_q;
  assign ROUTE_CLASH_O = clash_q;
  assign GPIO_IN_O = gpio_in_q;
  assign PERIPH_IN_O = periph_in_q;
  assign RESET_PIN_N_O = reset_n_q;
  assign SLOT_SPI_ACT_O = spi_act_q;
  assign SLOT_I2C_ACT_O = i2c_act_q;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // per-pin checks of the source selection
  for (genvar p = 0; p < NP; p++) begin : g_chk
    chk_route_out: assert property ( // [RQ1]
      route_ok_w[p] && !claim_w[p] |=>
        PAD_OUT_O[p] == $past(PERIPH_OUT_I[PIN_CFG_I[p].sig_idx]))
      else $error("routed pin does not follow its peripheral");
    chk_claim_wins: assert property ( // [RQ2]
      claim_w[p] && route_ok_w[p] |=> ROUTE_CLASH_O[p] && PAD_OE_O[p] == $past(ded_oe_w[p]))
      else $error("dedicated pin shared with a peripheral");
    chk_gpio_default: assert property ( // [RQ8]
      !route_ok_w[p] && !claim_w[p] |=>
        PAD_OUT_O[p] == $past(GPIO_OUT_I[p]) && PAD_OE_O[p] == $past(GPIO_OE_I[p]))
      else $error("unrouted pin left general-purpose control");
  end

  chk_analog_release: assert property ( // [RQ3]
    DEDICATED_EN_I.analog_input_channels[7] |=>
      !PAD_OE_O[31] && ROUTE_CLASH_O[31] == $past(route_ok_w[31]))
    else $error("analog pin still driven");
  chk_reset_follow: assert property ( // [RQ3]
    DEDICATED_EN_I.reset_pin && !PAD_IN_I[18] ##1 DEDICATED_EN_I.reset_pin [*2] |=>
      !RESET_PIN_N_O)
    else $error("reset pin low not seen three cycles on");
  chk_trace_pins: assert property ( // [RQ4]
    DEDICATED_EN_I.trace |=> PAD_OE_O[7] && PAD_OE_O[32] && PAD_OE_O[41] &&
      PAD_OUT_O[32] == $past(TRACE_DATA_BUS_I[0]) && PAD_OUT_O[7] == $past(TRACE_CLOCK_OUT_I))
    else $error("trace not on its fixed pins");
  chk_xtal_nfc: assert property ( // [RQ5]
    DEDICATED_EN_I.slow_crystal && DEDICATED_EN_I.nearfield_antenna |=>
      !PAD_OE_O[0] && !PAD_OE_O[1] && !PAD_OE_O[9] && !PAD_OE_O[10])
    else $error("crystal or antenna pin driven");

  // spi owns slot 0 while its own request stays up
  sequence s_spi_owns;
    SLOT_SPI_ACT_O[0] && SLOT_SPI_REQ_I[0];
  endsequence
  // i2c can win at the earliest one cycle after the owner lets go
  sequence s_i2c_waits;
    !SLOT_I2C_ACT_O[0] [*2];
  endsequence
  chk_slot_excl: assert property ( // [RQ6]
    s_spi_owns ##0 SLOT_SPI_REQ_I[0] [*3] |-> ##1 SLOT_SPI_ACT_O[0] ##0 s_i2c_waits)
    else $error("shared slot granted to both peripherals");
  chk_slot_never_both: assert property ( // [RQ6]
    !(SLOT_SPI_ACT_O[1] && SLOT_I2C_ACT_O[1]) && !(SLOT_SPI_ACT_O[0] && SLOT_I2C_ACT_O[0]))
    else $error("both peripherals of a slot active");
endmodule : ppm_pin_mux

// file: verif/ppm_pad_model.sv
`timescale 1ns/1ps
// board side of the pads: pins not driven by the block show the outside level
module ppm_pad_model (
  input wire logic [47:0] pad_out_i,
  input wire logic [47:0] pad_oe_i,
  input wire logic [47:0] ext_i,
  output logic [47:0] pad_o
);
  // resolved wire; the outside circuit always drives, so no pin floats to x
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule : ppm_pad_model

// file: verif/tb.sv
`timescale 1ns/1ps
`include "ppm_map.svh"
module tb;
  import ppm_pkg::*;
  // one expected result, due at a given cycle
  typedef struct {int due; int sel; logic [47:0] exp; logic [47:0] msk;} ppm_note_type;
  localparam int NSIG = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ppm_pin_cfg_type [47:0] cfg = '0;
  logic [NSIG-1:0] p_out = '0, p_oe = '0, p_in;
  logic [47:0] g_out = '0, g_oe = '0, g_in, pad_in, pad_out, pad_oe, clash, ext = '0;
  ppm_dedicated_en_type ded = '0;
  logic t_clk = 1'b0;
  logic [3:0] t_dat = 4'h0;
  logic rst_pin_n;
  logic [1:0] s_req = 2'h0, i_req = 2'h0, s_act, i_act;
  int cyc = 0, n_errors = 0, checks_done = 0;
  ppm_note_type q[$];
  string nm[8] = '{"pad_out", "pad_oe", "gpio_in", "clash", "periph_in", "spi_act", "i2c_act",
    "reset_n"};

  ppm_pin_mux #(.NUM_SIG(NSIG)) DUT (.CLK_I(clk), .RESET_N_I(rst_n), .PIN_CFG_I(cfg),
    .PERIPH_OUT_I(p_out), .PERIPH_OE_I(p_oe), .PERIPH_IN_O(p_in), .GPIO_OUT_I(g_out),
    .GPIO_OE_I(g_oe), .GPIO_IN_O(g_in), .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out),
    .PAD_OE_O(pad_oe), .DEDICATED_EN_I(ded), .TRACE_CLOCK_OUT_I(t_clk),
    .TRACE_DATA_BUS_I(t_dat), .RESET_PIN_N_O(rst_pin_n), .ROUTE_CLASH_O(clash),
    .SLOT_SPI_REQ_I(s_req), .SLOT_I2C_REQ_I(i_req), .SLOT_SPI_ACT_O(s_act),
    .SLOT_I2C_ACT_O(i_act));
  ppm_pad_model pads (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext), .pad_o(pad_in));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  // cycle count, read by driver and watcher alike
  always @(posedge clk) cyc <= cyc + 1;

  // output picked by a note
  function automatic logic [47:0] seen(int s);
    case (s)
      0: return pad_out;
      1: return pad_oe;
      2: return g_in;
      3: return clash;
      4: return 48'(p_in);
      5: return 48'(s_act);
      6: return 48'(i_act);
      default: return 48'(rst_pin_n);
    endcase
  endfunction : seen

  task automatic chk(string w, logic [47:0] s, logic [47:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask : chk

  task automatic push(int lat, int sel, logic [47:0] e, logic [47:0] m);
    q.push_back('{cyc + lat, sel, e & m, m});
  endtask : push

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic give_verdict();
    if (q.size() != 0) n_errors++;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // watcher: settled outputs at the falling edge against notes that fall due
  always @(negedge clk) begin
    for (int i = 0; i < q.size(); ) begin
      if (q[i].due == cyc) begin
        chk(nm[q[i].sel], seen(q[i].sel) & q[i].msk, q[i].exp);
        q.delete(i);
      end else begin
        i++;
      end
    end
  end

  // one random cycle pair: routes, dedicated functions, gpio and outside levels
  task automatic rnd_step();
    logic [47:0] claim, trm, valid, eo, ex, tv;
    int s;
    for (int p = 0; p < 48; p++) begin
      cfg[p].route_en = 1'($urandom);
      cfg[p].sig_idx = 6'($urandom_range(0, 47)); // above 39 must fall back to gpio
    end
    p_out = 40'({$urandom, $urandom});
    p_oe = 40'({$urandom, $urandom});
    g_out = 48'({$urandom, $urandom});
    g_oe = 48'({$urandom, $urandom});
    ext = 48'({$urandom, $urandom});
    ded = 12'($urandom);
    t_clk = 1'($urandom);
    t_dat = 4'($urandom);
    claim = '0;
    trm = '0;
    tv = '0;
    if (ded.slow_crystal) claim[1:0] = 2'h3;
    if (ded.nearfield_antenna) claim[10:9] = 2'h3;
    if (ded.reset_pin) claim[18] = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (ded.analog_input_channels[i]) claim[i < 4 ? 2 + i : 24 + i] = 1'b1;
    end
    // trace lanes on their own pins only
    if (ded.trace) begin
      trm = 48'h0000_0000_1880 | 48'h0201_0000_0000;
      tv[7] = t_clk;
      tv[32] = t_dat[0];
      tv[12] = t_dat[1];
      tv[11] = t_dat[2];
      tv[41] = t_dat[3];
    end
    for (int p = 0; p < 48; p++) begin
      s = cfg[p].sig_idx;
      valid[p] = cfg[p].route_en && s < NSIG;
      eo[p] = trm[p] ? 1'b1 : claim[p] ? 1'b0 : valid[p] ? p_oe[s] : g_oe[p];
      ex[p] = trm[p] ? tv[p] : valid[p] ? p_out[s] : g_out[p];
    end
    push(1, 0, ex, ~(claim & ~trm));
    push(1, 1, eo, '1);
    push(1, 3, valid & (claim | trm), '1);
    push(4, 2, (eo & ex) | (~eo & ext), '1);
    tick(2);
  endtask : rnd_step

  initial begin
    void'($urandom(32'h3C2BA591));
    tick(9);
    chk("pad_oe", pad_oe, 48'h0);
    chk("reset_n", 48'(rst_pin_n), 48'h1);
    tick(1);
    rst_n = 1'b1;
    tick(1);
    repeat (60) rnd_step();
    $display("test random routing done");
    // inputs: a claimed analog pin must not feed its routed peripheral
    cfg = '0;
    p_oe = '0;
    g_oe = '0;
    ded = '0;
    cfg[3] = '{1'b1, 6'h05};
    cfg[20] = '{1'b1, 6'h05};
    ded.analog_input_channels = 8'h02;
    ded.reset_pin = 1'b1;
    ext = 48'h0000_0000_0008;
    tick(1);
    push(4, 4, 48'h0, 48'h20);
    push(4, 7, 48'h0, '1);
    tick(5);
    ext = 48'h0000_0014_0000;
    tick(1);
    push(4, 4, 48'h20, 48'h20);
    push(4, 7, 48'h1, '1);
    tick(5);
    $display("test input path done");
    // shared slots: owner keeps it; switch only after owner clears
    for (int s = 0; s < 2; s++) begin
      for (int j = 0; j < 10; j++) begin
        s_req = 2'(10'h08F >> j & 10'h001) << s;
        i_req = 2'(10'h0BE >> j & 10'h001) << s;
        push(1, 5, 48'(10'h08F >> j & 10'h001) << s, '1);
        push(1, 6, 48'(10'h020 >> j & 10'h001) << s, '1);
        tick(1);
      end
    end
    tick(2);
    $display("test shared slots done");
    give_verdict();
  end

  // hang guard
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end
endmodule : tb
